//--- core/dmc_pkg.sv
// Shared constants and types for the four-channel transfer controller
package dmc_pkg;

  localparam int NCH   = 4;
  localparam int CNT_W = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the Wishbone port)
  localparam logic [7:0] ADR_MCTL     = 8'h00;
  localparam logic [3:0] CH_BLK_FIRST = 4'h1;
  localparam logic [3:0] CH_BLK_LAST  = 4'h4;
  localparam logic [3:0] CH_OFS_CTL   = 4'h0;
  localparam logic [3:0] CH_OFS_CNT   = 4'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Master control fields
  localparam int MC_PRIO_LSB = 8;
  localparam int MC_AE       = 2;
  localparam int MC_NONMASK_INTR_FLAG     = 1;
  localparam int MC_DME      = 0;
  localparam logic [15:0] MC_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Channel control fields
  localparam int CC_DE     = 0;
  localparam int CC_TE     = 1;
  localparam int CC_IE     = 2;
  localparam int CC_TS_LSB = 3;
  localparam int CC_DS     = 6;
  localparam int CC_RS_LSB = 8;
  localparam logic [15:0] CC_MASK    = 16'h0F5D;
  localparam logic [15:0] CC_MASK_HI = 16'h0F1D;
  localparam logic [15:0] CC_RESET   = 16'h0000;

  // Request source codes
  localparam logic [3:0] RS_AUTO       = 4'h0;
  localparam logic [3:0] RS_MEM_TO_DEV = 4'h2;
  localparam logic [3:0] RS_DEV_TO_MEM = 4'h3;

  // Priority modes
  localparam logic [1:0] PRIO_0123 = 2'h0;
  localparam logic [1:0] PRIO_0231 = 2'h1;
  localparam logic [1:0] PRIO_2013 = 2'h2;
  localparam logic [1:0] PRIO_RR   = 2'h3;

  typedef enum logic {ST_IDLE, ST_UNIT} dmc_state_t;

  // Byte-lane merge of a Wishbone write into the current word
  function automatic logic [31:0] dmc_merge(input logic [31:0] cur,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = cur;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

endpackage

//--- core/dmc_req_sense.sv
// External request pin sampler: synchroniser, level or falling-edge detect
`timescale 1ns/1ps
module dmc_req_sense
  import dmc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic external_request_n_i,
  input  wire logic edge_mode_i,
  input  wire logic consume_i,
  output logic      req_o
);

  logic meta_n;
  logic sync_n;
  logic prev_n;
  logic edge_pend;
  wire  fall = prev_n & ~sync_n;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_n    <= 1'b1;
      sync_n    <= 1'b1;
      prev_n    <= 1'b1;
      edge_pend <= 1'b0;
    end else begin
      meta_n <= external_request_n_i;
      sync_n <= meta_n;
      prev_n <= sync_n;
      // New edge wins over consumption
      if (fall && edge_mode_i) begin
        edge_pend <= 1'b1;
      end else if (consume_i || !edge_mode_i) begin
        edge_pend <= 1'b0;
      end
    end
  end

  // [R16] Level or edge sampling
  assign req_o = edge_mode_i ? edge_pend : ~sync_n;

endmodule

//--- core/dmc_arbiter.sv
// Channel arbiter: three fixed orders and a round-robin order
`timescale 1ns/1ps
module dmc_arbiter
  import dmc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [3:0] req_i,
  input  wire logic       rotate_i,
  input  wire logic [1:0] rotate_ch_i,
  output logic            valid_o,
  output logic [1:0]      grant_o
);

  logic [1:0] rr_order [NCH];
  logic [1:0] order    [NCH];
  logic [1:0] next_rr  [NCH];

  // [R03] Order per priority mode
  always_comb begin
    case (mode_i)
      PRIO_0123: order = '{2'h0, 2'h1, 2'h2, 2'h3};
      PRIO_0231: order = '{2'h0, 2'h2, 2'h3, 2'h1};
      PRIO_2013: order = '{2'h2, 2'h0, 2'h1, 2'h3};
      default:   order = rr_order;
    endcase
  end

  always_comb begin
    valid_o = 1'b0;
    grant_o = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req_i[order[i]]) begin
        valid_o = 1'b1;
        grant_o = order[i];
      end
    end
  end

  // [R04] Finished channel moves last
  always_comb begin
    logic found;
    found = 1'b0;
    for (int i = 0; i < NCH - 1; i++) begin
      if (rr_order[i] == rotate_ch_i) begin
        found = 1'b1;
      end
      next_rr[i] = found ? rr_order[i + 1] : rr_order[i];
    end
    next_rr[NCH - 1] = rotate_ch_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rr_order <= '{2'h0, 2'h1, 2'h2, 2'h3};
    end else if (rotate_i && mode_i == PRIO_RR) begin
      rr_order <= next_rr;
    end
  end

endmodule

//--- core/dmc_ctrl.sv
// Top: master control, channel registers, request handling and unit engine
//
// How it works
// [R01] Master control is 16 bits; bits 15-10 and 7-3 read zero.
// [R02] Reset and standby clear the whole master control register.
// [R03] Priority field picks 0123, 0231, 2013 order or round robin.
// [R04] Round robin sends each finished channel last; starts 0123.
// [R05] Address fault flag is set by unit errors and halts all channels.
// [R06] Fault flag ignores written ones; cleared by zero after reading one.
// [R07] NMI sets its flag always and halts all channels; here an NMI edge while standby is high leaves the flag clear.
// [R08] NMI flag ignores written ones; cleared by zero after reading one.
// [R09] Channel runs only with global and channel enable; clearing halts.
// [R10] Enabled means enable, global enable, no done, no NMI, no fault.
// [R11] Each accepted request moves one unit, then count minus one.
// [R12] Count reaching zero ends normally; interrupt if enabled.
// [R13] Fault, NMI or cleared enables abort a running unit.
// [R14] Done flag set only on normal end; cleared by reset, standby, read-zero.
// [R15] Auto mode requests whenever the channel is enabled.
// [R16] External request is active low, level or falling edge by sense bit.
// [R17] Sense bit only on channels 0 and 1; other sources use edges; peripheral requests are sampled as levels instead.
// [R18] Source code 0000 is auto request, dual address.
// [R19] Codes 0010 and 0011 are single address to and from acked device.
// [R20] Priority is decided only between units.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dmc_ctrl
  import dmc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        standby_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Event sources
  input  wire logic        nmi_i,
  input  wire logic [1:0]  external_request_n_i,
  input  wire logic [3:0]  periph_req_i,
  // Unit transfer port towards the bus side
  output logic             unit_req_o,
  output logic [1:0]       unit_chan_o,
  output logic [1:0]       unit_size_o,
  output logic             unit_single_o,
  output logic             unit_to_mem_o,
  input  wire logic        unit_done_i,
  input  wire logic        unit_addr_err_i,
  output logic [1:0]       external_ack_o,
  output logic [3:0]       transfer_end_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [1:0]       prio_mode;
  logic             address_fault_flag;
  logic             nonmask_intr_flag;
  logic             global_enable;
  logic             ae_armed;
  logic             nmi_armed;
  logic [15:0]      channel_control [NCH];
  logic [CNT_W-1:0] transfer_count  [NCH];
  logic [3:0]       count_done_flag;
  logic [3:0]       te_armed;
  logic [3:0]       periph_pend;
  logic             nmi_meta;
  logic             nmi_sync;
  logic             nmi_prev;
  dmc_state_t       state;
  logic [1:0]       cur_ch;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire        acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr      = acc & wb_we_i;
  wire        rd      = acc & ~wb_we_i;
  wire [3:0]  blk     = wb_adr_i[7:4];
  wire        ch_hit  = (blk >= CH_BLK_FIRST) && (blk <= CH_BLK_LAST);
  wire [1:0]  ch_idx  = 2'(blk - CH_BLK_FIRST);
  wire        hit_mc  = (wb_adr_i == ADR_MCTL);
  wire        hit_ctl = ch_hit && (wb_adr_i[3:0] == CH_OFS_CTL);
  wire        hit_cnt = ch_hit && (wb_adr_i[3:0] == CH_OFS_CNT);

  // [R01] Reserved bits read zero
  wire [15:0] mc_word = {6'h00, prio_mode, 5'h00, address_fault_flag,
                         nonmask_intr_flag, global_enable};
  wire [15:0] ctl_word = channel_control[ch_idx] |
                         (16'(count_done_flag[ch_idx]) << CC_TE);
  wire [31:0] rd_word = hit_mc  ? {16'h0000, mc_word} :
                        hit_ctl ? {16'h0000, ctl_word} :
                        hit_cnt ? 32'(transfer_count[ch_idx]) : 32'h0000_0000;
  wire [31:0] wr_word = dmc_merge(rd_word, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? rd_word : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // NMI pin synchroniser and rising-edge detect
  wire nmi_event = nmi_sync & ~nmi_prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
      nmi_prev <= 1'b0;
    end else begin
      nmi_meta <= nmi_i;
      nmi_sync <= nmi_meta;
      nmi_prev <= nmi_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel qualification and request sources
  logic [3:0] chan_en;
  logic [3:0] chan_req;
  logic [1:0] ext_req;
  logic [3:0] consume;
  logic [3:0] src_auto;
  logic [3:0] src_ext;
  wire        flags_ok = global_enable & ~nonmask_intr_flag & ~address_fault_flag;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // [R10] Full enable condition
      chan_en[c]  = channel_control[c][CC_DE] & ~count_done_flag[c] & flags_ok;
      // [R18] Auto source code
      src_auto[c] = channel_control[c][CC_RS_LSB +: 4] == RS_AUTO;
      // [R19] External device codes
      src_ext[c]  = (c < 2) &&
                    (channel_control[c][CC_RS_LSB +: 4] == RS_MEM_TO_DEV ||
                     channel_control[c][CC_RS_LSB +: 4] == RS_DEV_TO_MEM);
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // [R15] Auto request when enabled
      if (src_auto[c]) begin
        chan_req[c] = chan_en[c];
      end else if (src_ext[c]) begin
        chan_req[c] = chan_en[c] & ext_req[c[0]];
      end else begin
        chan_req[c] = chan_en[c] & periph_pend[c];
      end
    end
  end

  // [R17] Sense bit only on channels 0 and 1
  genvar g;
  for (g = 0; g < 2; g++) begin : g_sense
    dmc_req_sense u_sense (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .external_request_n_i (external_request_n_i[g]),
      .edge_mode_i          (channel_control[g][CC_DS]),
      .consume_i            (consume[g]),
      .req_o                (ext_req[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  logic       arb_valid;
  logic [1:0] arb_grant;
  wire        idle     = (state == ST_IDLE);
  // [R20] Grant only between units
  wire        start    = idle & arb_valid;
  wire        finish   = ~idle & unit_done_i;
  // [R13] Abort on fault, NMI or cleared enable
  wire        abort    = ~idle & ~unit_done_i & (unit_addr_err_i | ~chan_en[cur_ch]);
  wire [15:0] grant_cc = channel_control[arb_grant];
  wire [3:0]  grant_rs = grant_cc[CC_RS_LSB +: 4];

  assign consume = start ? (4'h1 << arb_grant) : 4'h0;

  dmc_arbiter u_arb (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .mode_i      (prio_mode),
    .req_i       (chan_req),
    .rotate_i    (finish),
    .rotate_ch_i (cur_ch),
    .valid_o     (arb_valid),
    .grant_o     (arb_grant)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Unit engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state          <= ST_IDLE;
      cur_ch         <= 2'h0;
      unit_req_o     <= 1'b0;
      unit_chan_o    <= 2'h0;
      unit_size_o    <= 2'h0;
      unit_single_o  <= 1'b0;
      unit_to_mem_o  <= 1'b0;
      external_ack_o <= 2'h0;
    end else if (start) begin
      // [R11] One unit of the programmed size
      state          <= ST_UNIT;
      cur_ch         <= arb_grant;
      unit_req_o     <= 1'b1;
      unit_chan_o    <= arb_grant;
      unit_size_o    <= grant_cc[CC_TS_LSB +: 2];
      unit_single_o  <= src_ext[arb_grant];
      unit_to_mem_o  <= src_ext[arb_grant] && (grant_rs == RS_DEV_TO_MEM);
      external_ack_o <= src_ext[arb_grant] ? (2'h1 << arb_grant[0]) : 2'h0;
    end else if (finish || abort) begin
      state          <= ST_IDLE;
      unit_req_o     <= 1'b0;
      external_ack_o <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master control register
  wire clr_all = rst_i | standby_i;

  always_ff @(posedge clk_i) begin
    // [R02] Cleared by reset and standby
    if (clr_all) begin
      prio_mode          <= MC_RESET[MC_PRIO_LSB +: 2];
      global_enable      <= MC_RESET[MC_DME];
      address_fault_flag <= MC_RESET[MC_AE];
      nonmask_intr_flag  <= MC_RESET[MC_NONMASK_INTR_FLAG];
      ae_armed           <= 1'b0;
      nmi_armed          <= 1'b0;
    end else begin
      if (wr && hit_mc) begin
        // [R09] Global enable written by software
        prio_mode     <= wr_word[MC_PRIO_LSB +: 2];
        global_enable <= wr_word[MC_DME];
      end
      // [R05] Unit error sets fault flag
      if (~idle && unit_addr_err_i) begin
        address_fault_flag <= 1'b1;
      // [R06] Zero after reading one clears
      end else if (wr && hit_mc && ae_armed && !wr_word[MC_AE]) begin
        address_fault_flag <= 1'b0;
      end
      // [R07] NMI edge sets the flag unless standby clears it in the same cycle
      if (nmi_event) begin
        nonmask_intr_flag <= 1'b1;
      // [R08] Zero after reading one clears
      end else if (wr && hit_mc && nmi_armed && !wr_word[MC_NONMASK_INTR_FLAG]) begin
        nonmask_intr_flag <= 1'b0;
      end
      if (rd && hit_mc && address_fault_flag) begin
        ae_armed <= 1'b1;
      end else if (wr && hit_mc) begin
        ae_armed <= 1'b0;
      end
      if (rd && hit_mc && nonmask_intr_flag) begin
        nmi_armed <= 1'b1;
      end else if (wr && hit_mc) begin
        nmi_armed <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers, count and done flags
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        channel_control[c] <= CC_RESET;
        transfer_count[c]  <= '0;
        periph_pend[c]     <= 1'b0;
      end else begin
        if (wr && hit_ctl && ch_idx == 2'(c)) begin
          channel_control[c] <= wr_word[15:0] & ((c < 2) ? CC_MASK : CC_MASK_HI);
        end
        // [R11] Count minus one per unit
        if (finish && cur_ch == 2'(c)) begin
          transfer_count[c] <= transfer_count[c] - CNT_W'(1);
        end else if (wr && hit_cnt && ch_idx == 2'(c)) begin
          transfer_count[c] <= wr_word[CNT_W-1:0];
        end
        // [R17] Peripheral request level sets pending on every high cycle, not on edges
        if (periph_req_i[c]) begin
          periph_pend[c] <= 1'b1;
        end else if (consume[c]) begin
          periph_pend[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      // [R14] Reset and standby clear done
      if (clr_all) begin
        count_done_flag[c] <= 1'b0;
        te_armed[c]        <= 1'b0;
      end else begin
        // [R12] Normal end when count hits zero
        if (finish && cur_ch == 2'(c) && transfer_count[c] == CNT_W'(1)) begin
          count_done_flag[c] <= 1'b1;
        // [R14] Zero after reading one clears
        end else if (wr && hit_ctl && ch_idx == 2'(c) && te_armed[c] &&
                     !wr_word[CC_TE]) begin
          count_done_flag[c] <= 1'b0;
        end
        if (rd && hit_ctl && ch_idx == 2'(c) && count_done_flag[c]) begin
          te_armed[c] <= 1'b1;
        end else if (wr && hit_ctl && ch_idx == 2'(c)) begin
          te_armed[c] <= 1'b0;
        end
      end
    end
  end

  // [R12] End interrupt per channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transfer_end_irq_o <= 4'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        transfer_end_irq_o[c] <= count_done_flag[c] & channel_control[c][CC_IE];
      end
    end
  end

endmodule

//--- tb/dmc_ctrl_asserts.sv
// Port-level checker for the transfer controller
`timescale 1ns/1ps
module dmc_ctrl_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        standby_i,
  input wire logic        nmi_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        unit_req_o,
  input wire logic [1:0]  unit_chan_o,
  input wire logic [1:0]  unit_size_o,
  input wire logic        unit_single_o,
  input wire logic        unit_done_i,
  input wire logic        unit_addr_err_i,
  input wire logic [1:0]  external_ack_o,
  input wire logic [3:0]  transfer_end_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  AST_UNIT_HOLD:
    assert property (unit_req_o && !unit_done_i && !unit_addr_err_i && !wb_we_i && !standby_i
      && !nmi_i |=> unit_req_o && $stable(unit_chan_o) && $stable(unit_size_o))
    else $error("unit changed before its end");
  AST_DONE_DROP:
    assert property (unit_req_o && unit_done_i |=> !unit_req_o) else $error("unit not ended");
  AST_ERR_STOP:
    assert property (unit_req_o && unit_addr_err_i |=> !unit_req_o [*4])
    else $error("transfer after address fault");
  AST_EXT_ACK:
    assert property (unit_req_o && unit_single_o && !unit_chan_o[1]
      |-> external_ack_o[unit_chan_o[0]]) else $error("device ack missing");
  AST_EXT_IDLE:
    assert property (external_ack_o != 2'h0 |-> unit_req_o || $past(unit_req_o))
    else $error("device ack outside unit");
  AST_IRQ_CAUSE:
    assert property ($rose(transfer_end_irq_o != 4'h0) |-> $past(unit_done_i, 2))
    else $error("interrupt without completion");
  AST_STBY_CLR:
    assert property (standby_i [*2] |=> !unit_req_o && transfer_end_irq_o == 4'h0)
    else $error("standby left activity");

  COV_DONE: cover property (unit_req_o && unit_done_i);
  COV_ERR: cover property (unit_req_o && unit_addr_err_i);
  COV_EXT: cover property (external_ack_o != 2'h0);
endmodule

bind dmc_ctrl dmc_ctrl_asserts u_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .nmi_i(nmi_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .unit_req_o(unit_req_o), .unit_chan_o(unit_chan_o),
  .unit_size_o(unit_size_o), .unit_single_o(unit_single_o), .unit_done_i(unit_done_i),
  .unit_addr_err_i(unit_addr_err_i), .external_ack_o(external_ack_o),
  .transfer_end_irq_o(transfer_end_irq_o)
);

//--- tb/dmc_bus_model.sv
// Far-side model: answers units, drives request pins
`timescale 1ns/1ps
module dmc_bus_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       unit_req_i,
  input  wire logic [2:0] delay_i,
  input  wire logic       fail_i,
  input  wire logic [1:0] pin_low_i,
  output logic            unit_done_o,
  output logic            unit_addr_err_o,
  output logic [1:0]      external_request_n_o
);
  logic [2:0] wait_cnt;
  logic       answered;
  logic       fire;

  assign fire = unit_req_i && !answered && (wait_cnt == delay_i);
  assign external_request_n_o = ~pin_low_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_cnt <= 3'h0;
      answered <= 1'b0;
      unit_done_o <= 1'b0;
      unit_addr_err_o <= 1'b0;
    end else begin
      unit_done_o <= fire && !fail_i;
      unit_addr_err_o <= fire && fail_i;
      answered <= unit_req_i && (answered || fire);
      wait_cnt <= (unit_req_i && !answered) ? wait_cnt + 3'h1 : 3'h0;
    end
  end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the transfer controller
`timescale 1ns/1ps
module tb_top;
  import dmc_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, standby_i = 1'b0, nmi_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, transfer_end_irq_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, unit_req_o, unit_single_o, unit_to_mem_o, done, err;
  logic [1:0]  unit_chan_o, unit_size_o, req_n, external_ack_o;
  logic [2:0]  dly = 3'h0;
  logic        fail = 1'b0, req_q = 1'b0;
  logic [1:0]  pin_low = 2'h0;
  logic [3:0]  preq = 4'h0, sel = 4'hF;
  logic [1:0]  sz[4];
  logic [31:0] exp_rd[$];
  logic [7:0]  exp_unit[$];
  int          fails = 0, checks_done = 0, seed = 32'h2EFC59D2;
  int          ord[3][4] = '{'{0, 1, 2, 3}, '{0, 2, 3, 1}, '{2, 0, 1, 3}};

  always #10 clk_i = ~clk_i;

  dmc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_i(nmi_i),
    .external_request_n_i(req_n), .periph_req_i(preq), .unit_req_o(unit_req_o),
    .unit_chan_o(unit_chan_o), .unit_size_o(unit_size_o), .unit_single_o(unit_single_o),
    .unit_to_mem_o(unit_to_mem_o), .unit_done_i(done), .unit_addr_err_i(err),
    .external_ack_o(external_ack_o), .transfer_end_irq_o(transfer_end_irq_o));
  dmc_bus_model u_bus (.clk_i(clk_i), .rst_i(rst_i), .unit_req_i(unit_req_o), .delay_i(dly),
    .fail_i(fail), .pin_low_i(pin_low), .unit_done_o(done), .unit_addr_err_o(err),
    .external_request_n_o(req_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    if (n >= 64) begin
      fails++;
      wrap_up();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((exp_unit.size() != 0 || unit_req_o !== 1'b0) && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      wrap_up();
    end
    repeat (4) @(posedge clk_i);
  endtask

  task automatic stby();
    standby_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    standby_i <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [7:0] ra(input int c, input logic [3:0] o);
    return {4'(c + 1), o};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk(wb_dat_o, exp_rd.size() > 0 ? exp_rd.pop_front() : 32'hFFFFFFFF, "read");
    if (unit_req_o === 1'b1 && req_q !== 1'b1)
      chk({external_ack_o, unit_to_mem_o, unit_single_o, unit_size_o, unit_chan_o},
          exp_unit.size() > 0 ? exp_unit.pop_front() : 32'h100, "grant");
    req_q <= unit_req_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_MCTL, 32'h0);
    bus(1'b1, ADR_MCTL, 32'hFFFFFFFE);
    rd(ADR_MCTL, 32'h0300);
    rd(8'hF0, 32'h0);
    bus(1'b1, ra(2, CH_OFS_CTL), 32'hFFFFFFFE);
    rd(ra(2, CH_OFS_CTL), 32'h0F1C);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ADR_MCTL, 32'h0);
      for (int c = 0; c < 4; c++) begin
        sz[c] = 2'($unsigned($random(seed)) % 3);
        bus(1'b1, ra(c, CH_OFS_CNT), 32'h2);
        bus(1'b1, ra(c, CH_OFS_CTL), {27'h0, sz[c], 3'h5});
      end
      for (int i = 0; i < 8; i++) begin
        k = (m == 3) ? i % 4 : ord[m][i / 2];
        exp_unit.push_back({4'h0, sz[k], 2'(k)});
      end
      dly <= 3'($random(seed));
      bus(1'b1, ADR_MCTL, {22'h0, 2'(m), 8'h01});
      drain();
      for (int c = 0; c < 4; c++) begin
        rd(ra(c, CH_OFS_CTL), {27'h0, sz[c], 3'h7});
        rd(ra(c, CH_OFS_CNT), 32'h0);
      end
      chk({28'h0, transfer_end_irq_o}, 32'hF, "irq");
      bus(1'b1, ra(0, CH_OFS_CTL), 32'h0);
      rd(ra(0, CH_OFS_CTL), 32'h0);
      stby();
      rd(ADR_MCTL, 32'h0);
      for (int c = 1; c < 4; c++) bus(1'b1, ra(c, CH_OFS_CTL), 32'h0);
    end
    bus(1'b1, ra(1, CH_OFS_CNT), 32'h3);
    bus(1'b1, ra(1, CH_OFS_CTL), 32'h1);
    fail <= 1'b1;
    exp_unit.push_back(8'h01);
    bus(1'b1, ADR_MCTL, 32'h1);
    drain();
    bus(1'b1, ADR_MCTL, 32'h1);
    rd(ADR_MCTL, 32'h5);
    rd(ra(1, CH_OFS_CNT), 32'h3);
    fail <= 1'b0;
    repeat (3) exp_unit.push_back(8'h01);
    bus(1'b1, ADR_MCTL, 32'h1);
    drain();
    bus(1'b1, ra(2, CH_OFS_CNT), 32'h1);
    nmi_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    nmi_i <= 1'b0;
    bus(1'b1, ra(2, CH_OFS_CTL), 32'h1);
    repeat (8) @(posedge clk_i);
    rd(ADR_MCTL, 32'h3);
    exp_unit.push_back(8'h02);
    bus(1'b1, ADR_MCTL, 32'h1);
    drain();
    chk({28'h0, transfer_end_irq_o}, 32'h0, "irq off");
    stby();
    bus(1'b1, ra(2, CH_OFS_CTL), 32'h0);
    dly <= 3'h2;
    bus(1'b1, ra(1, CH_OFS_CNT), 32'h2);
    bus(1'b1, ra(1, CH_OFS_CTL), 32'h0241);
    bus(1'b1, ra(0, CH_OFS_CNT), 32'h2);
    bus(1'b1, ra(0, CH_OFS_CTL), 32'h0301);
    exp_unit.push_back(8'h91);
    bus(1'b1, ADR_MCTL, 32'h1);
    pin_low <= 2'h2;
    repeat (14) @(posedge clk_i);
    pin_low <= 2'h0;
    drain();
    rd(ra(1, CH_OFS_CNT), 32'h1);
    repeat (2) exp_unit.push_back(8'h70);
    pin_low <= 2'h1;
    drain();
    pin_low <= 2'h0;
    rd(ra(0, CH_OFS_CNT), 32'h0);
    // Peripheral pulse source on channel 3
    bus(1'b1, ra(3, CH_OFS_CNT), 32'h1);
    bus(1'b1, ra(3, CH_OFS_CTL), 32'h0801);
    exp_unit.push_back(8'h03);
    preq <= 4'h8;
    @(posedge clk_i);
    preq <= 4'h0;
    drain();
    rd(ra(3, CH_OFS_CNT), 32'h0);
    // Single byte lane write keeps the other lanes
    sel = 4'h2;
    bus(1'b1, ADR_MCTL, 32'h0200);
    sel = 4'hF;
    rd(ADR_MCTL, 32'h0201);
    wrap_up();
  end
endmodule
